// File: core/rsp_ctrl.sv
// Return stack pointer control: pointer, storage, full and underflow flags.
// Assumes push and pop never both high; pc is the value to store, or pc plus two on the push that raises a fault reset.
//
// Design decisions made here: strobed register access and the address map.
`default_nettype none
`include "rsp_defs.svh"
module rsp_ctrl (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  // Configuration
  input wire logic stack_fault_reset_enable,
  // Sequencer requests
  input wire rsp_pkg::rsp_req_s req,
  // Software register port
  input wire rsp_pkg::rsp_bus_s bus,
  output logic [7:0] rdata_q,
  // Results
  output logic [`RSP_PC_W-1:0] top_stack_entry,
  output logic [`RSP_LVL_W-1:0] stack_level_field,
  output logic stack_full_flag,
  output logic stack_underflow_flag,
  output logic device_reset_req_q,
  output logic irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [`RSP_LVL_W-1:0] lvl_q, lvl_d; // Pointer
  logic [`RSP_PC_W-1:0] mem_q [`RSP_DEPTH]; // Entries, index 0 unused
  logic wr_en; // Store at next level
  logic [`RSP_LVL_W-1:0] wr_idx; // Store index
  logic [`RSP_PC_W-1:0] wr_val; // Store value
  logic full_set, unf_set; // Events
  logic full_clr, unf_clr; // Software clears
  logic rst_req_d; // Fault reset request
  logic [`RSP_IRQ_W-1:0] mask_q, mask_d; // Interrupt mask
  logic [`RSP_IRQ_W-1:0] istat; // Status view
  logic [7:0] rdata_d; // Read data
  logic ptr_wr; // Software writes the pointer register
  logic stat_wr; // Software writes interrupt status

  assign ptr_wr = bus.wr && (bus.addr == `RSP_OFF_PTR);
  assign stat_wr = bus.wr && (bus.addr == `RSP_OFF_IRQ_STAT);

  // ---------------------------------------------------------------
  // Pointer and storage
  // ---------------------------------------------------------------
  // Next pointer and store decision
  always_comb begin
    lvl_d = lvl_q;
    wr_en = 1'b0;
    wr_idx = lvl_q + 5'h01;
    wr_val = req.pc;
    full_set = 1'b0;
    unf_set = 1'b0;
    rst_req_d = 1'b0;
    if (req.push) begin
      if (lvl_q == `RSP_LVL_MAX) begin
        // Saturated: keep the last entry and level
        full_set = 1'b1;
      end else if (lvl_q == `RSP_LVL_MAX - 5'h01) begin
        // The thirty-first push fills the stack
        full_set = 1'b1;
        if (stack_fault_reset_enable) begin
          wr_en = 1'b1;
          wr_val = req.pc + `RSP_PC_STEP;
          rst_req_d = 1'b1;
          lvl_d = `RSP_LVL_ZERO;
        end else begin
          wr_en = 1'b1;
          lvl_d = `RSP_LVL_MAX;
        end
      end else begin
        wr_en = 1'b1;
        lvl_d = wr_idx;
      end
    end else if (req.pop) begin
      if (lvl_q == `RSP_LVL_ZERO) begin
        // Empty: top reads zero, pointer stays; no reset issued
        unf_set = 1'b1;
      end else begin
        lvl_d = lvl_q - 5'h01;
      end
    end else if (ptr_wr) begin
      lvl_d = bus.wdata[`RSP_LVL_W-1:0];
    end
  end

  // Pointer register; only rst_n zeroes it, por_n does not
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q <= `RSP_LVL_ZERO;
      device_reset_req_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      device_reset_req_q <= rst_req_d;
    end
  end

  // Entry storage, no reset needed since index 0 reads as zero
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_val;
    end
  end

  // Top entry; empty level shows zero for the sequencer
  assign top_stack_entry = (lvl_q == `RSP_LVL_ZERO) ? '0 : mem_q[lvl_q];
  assign stack_level_field = lvl_q;

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  // Clear by writing zero to a flag bit or one to interrupt status
  always_comb begin
    full_clr = (ptr_wr && !bus.wdata[`RSP_FULL_BIT])
      || (stat_wr && bus.wdata[1]);
    unf_clr = (ptr_wr && !bus.wdata[`RSP_UNF_BIT])
      || (stat_wr && bus.wdata[0]);
  end

  // Full flag survives device resets; only power-on clears it
  rsp_flag u_full (
    .clk(clk),
    .por_n(por_n),
    .set(full_set),
    .clr(full_clr),
    .flag_q(stack_full_flag)
  );

  // Underflow flag, same sticky rules
  rsp_flag u_unf (
    .clk(clk),
    .por_n(por_n),
    .set(unf_set),
    .clr(unf_clr),
    .flag_q(stack_underflow_flag)
  );

  // ---------------------------------------------------------------
  // Interrupt and read path
  // ---------------------------------------------------------------
  assign istat = {stack_full_flag, stack_underflow_flag};
  assign irq = |(istat & mask_q);

  // Mask and read data next values
  always_comb begin
    mask_d = mask_q;
    if (bus.wr && (bus.addr == `RSP_OFF_IRQ_MASK)) begin
      mask_d = bus.wdata[`RSP_IRQ_W-1:0];
    end
    rdata_d = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `RSP_OFF_PTR: rdata_d = {stack_full_flag, stack_underflow_flag, 1'b0, lvl_q};
        `RSP_OFF_IRQ_STAT: rdata_d = {6'h00, istat};
        `RSP_OFF_IRQ_MASK: rdata_d = {6'h00, mask_q};
        default: rdata_d = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // Mask and read data registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= 2'h0;
      rdata_q <= 8'h00;
    end else begin
      mask_q <= mask_d;
      rdata_q <= rdata_d;
    end
  end
endmodule // rsp_ctrl
`default_nettype wire

// File: core/rsp_defs.svh
// Constants for the return stack pointer control block.
// Assumes inclusion by bare name from any core file; definitions only.
`ifndef RSP_DEFS_SVH
`define RSP_DEFS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define RSP_ADDR_W 2
`define RSP_OFF_PTR 2'h0
`define RSP_OFF_IRQ_STAT 2'h1
`define RSP_OFF_IRQ_MASK 2'h2

// ---------------------------------------------------------------
// Field positions and sizes
// ---------------------------------------------------------------
`define RSP_FULL_BIT 7
`define RSP_UNF_BIT 6
`define RSP_LVL_W 5
`define RSP_PC_W 21
`define RSP_DEPTH 32
`define RSP_LVL_MAX 5'h1f
`define RSP_LVL_ZERO 5'h00
`define RSP_PC_STEP 21'h000002
`define RSP_IRQ_W 2

`endif

// File: core/rsp_pkg.sv
// Types for the return stack pointer control block.
// Assumes rsp_defs.svh is on the include path.
`default_nettype none
`include "rsp_defs.svh"
package rsp_pkg;
  // Stack operation request from the sequencer
  typedef struct packed {
    logic push;
    logic pop;
    logic [`RSP_PC_W-1:0] pc;
  } rsp_req_s;
  // Software register port
  typedef struct packed {
    logic [`RSP_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsp_bus_s;
endpackage
`default_nettype wire

// File: core/rsp_flag.sv
// One sticky flag: hardware sets, software clears, set wins.
// Assumes a synchronous reset that is power-on only.
`default_nettype none
module rsp_flag (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic por_n,
  // Set and clear
  input wire logic set,
  input wire logic clr,
  // State
  output logic flag_q
);
  logic flag_d; // Next value

  // Set wins over a clear in the same cycle
  always_comb begin
    flag_d = set | (flag_q & ~clr);
  end

  // Register, cleared only at power-on
  always_ff @(posedge clk) begin
    if (!por_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // rsp_flag
`default_nettype wire

// File: verification/rsp_seq.sv
// Sequencer model: issues push and pop requests to the stack.
// Assumes one clock; requests are one cycle long.
`default_nettype none
`include "rsp_defs.svh"
module rsp_seq (
  // Clock
  input wire logic clk,
  // Requests to the stack
  output var rsp_pkg::rsp_req_s req
);
  // Idle until the bench asks
  initial req = '0;
  // One pulse, never push and pop together
  task automatic op(input logic psh, input logic [`RSP_PC_W-1:0] pc);
    @(posedge clk);
    req <= '{push: psh, pop: !psh, pc: pc};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
endmodule // rsp_seq
`default_nettype wire

// File: verification/rsp_ctrl_asserts.sv
// Checker for the return stack pointer block.
// Assumes it sees only the ports of rsp_ctrl.
`default_nettype none
`include "rsp_defs.svh"
module rsp_ctrl_chk (
  // Clock, resets, config
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic stack_fault_reset_enable,
  // Requests and bus
  input wire rsp_pkg::rsp_req_s req,
  input wire rsp_pkg::rsp_bus_s bus,
  // Results
  input wire logic [7:0] rdata_q,
  input wire logic [`RSP_PC_W-1:0] top_stack_entry,
  input wire logic [`RSP_LVL_W-1:0] stack_level_field,
  input wire logic stack_full_flag,
  input wire logic stack_underflow_flag,
  input wire logic device_reset_req_q
);
  // Flags survive rst_n, so both resets gate the checks except reset_zero_a
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n || !por_n);
  wire logic [4:0] lv = stack_level_field;
  push_up_a: assert property (
    req.push && lv < 5'h1e |=> lv == $past(lv) + 5'h01 && top_stack_entry == $past(req.pc))
    else $error("push slip");
  pop_down_a: assert property (req.pop && lv != 5'h00 |=> lv == $past(lv) - 5'h01)
    else $error("pop slip");
  full_set_a: assert property (req.push && lv == 5'h1e |=> stack_full_flag)
    else $error("full not set");
  fault_rst_a: assert property (
    req.push && lv == 5'h1e && stack_fault_reset_enable
    |=> device_reset_req_q && lv == 5'h00 ##1 !device_reset_req_q) else $error("no reset");
  sat_hold_a: assert property (
    req.push && lv >= 5'h1e && !stack_fault_reset_enable |=> lv == 5'h1f) else $error("sat");
  unf_set_a: assert property (req.pop && lv == 5'h00 |=> stack_underflow_flag
    && lv == 5'h00 && top_stack_entry == '0 && !device_reset_req_q) else $error("unf");
  flags_keep_a: assert property (!bus.wr |=> stack_full_flag >= $past(stack_full_flag)
    && stack_underflow_flag >= $past(stack_underflow_flag)) else $error("flag lost");
  ptr_read_a: assert property (
    bus.rd && bus.addr == `RSP_OFF_PTR && !bus.wr && !req.push && !req.pop |=> rdata_q ==
    {$past(stack_full_flag), $past(stack_underflow_flag), 1'b0, $past(lv)}) else $error("rd");
  reset_zero_a: assert property (disable iff (1'b0) $rose(rst_n) |-> lv == 5'h00)
    else $error("reset level");
endmodule // rsp_ctrl_chk
bind rsp_ctrl rsp_ctrl_chk chk (.clk, .rst_n, .por_n, .stack_fault_reset_enable, .req, .bus,
  .rdata_q, .top_stack_entry, .stack_level_field, .stack_full_flag, .stack_underflow_flag,
  .device_reset_req_q);
`default_nettype wire

// File: verification/test_rsp_ctrl.sv
// Self-checking bench for rsp_ctrl with a sequencer model.
// Assumes the checker is bound in from its own file.
`default_nettype none
`include "rsp_defs.svh"
module test_rsp_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, outputs and the reference stack
  logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, fre_en = 1'b0, full, unf, dreq, irq, u = 1'b0;
  rsp_pkg::rsp_req_s req;
  rsp_pkg::rsp_bus_s bus = '0;
  logic [7:0] rdata_q;
  logic [`RSP_PC_W-1:0] top, st [32];
  logic [4:0] lvl;
  logic [31:0] seed = 32'heb9d102e, x;
  int n_mismatch = 0, check_count = 0, cyc = 0, lv = 0;
  always #2 clk = ~clk;
  rsp_seq seq (.clk(clk), .req(req));
  rsp_ctrl dut (.clk(clk), .rst_n(rst_n), .por_n(por_n), .stack_fault_reset_enable(fre_en),
    .req(req), .bus(bus), .rdata_q(rdata_q), .top_stack_entry(top), .stack_level_field(lvl),
    .stack_full_flag(full), .stack_underflow_flag(unf), .device_reset_req_q(dreq), .irq(irq));
  // Ceiling well above the 167 ops run
  always @(posedge clk) if (++cyc > 5000) begin
    n_mismatch++;
    summarize();
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Pointer register image
  function automatic logic [7:0] ptr_exp(logic f, logic n, logic [4:0] l);
    return {f, n, 1'b0, l};
  endfunction
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t mismatch", $time);
    end
  endtask
  // One register cycle; read data checked after return
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    acc(1'b1, `RSP_OFF_IRQ_MASK, 8'h03);
    chk(lvl === 5'h00);
    // Random walk; cap forces pops before full
    repeat (150) begin
      x = rnd();
      if (x[0] && lv < 29) begin
        seq.op(1'b1, x[20:0]);
        lv++;
        st[lv] = x[20:0];
      end else begin
        seq.op(1'b0, '0);
        u |= (lv == 0);
        if (lv > 0) lv--;
      end
      chk(lvl === 5'(lv) && top === (lv > 0 ? st[lv] : '0) && unf === u);
    end
    acc(1'b0, `RSP_OFF_PTR, 8'h00);
    chk(rdata_q === ptr_exp(1'b0, u, 5'(lv)) && irq === u);
    acc(1'b1, `RSP_OFF_IRQ_STAT, 8'h03);
    acc(1'b1, `RSP_OFF_PTR, 8'h1d);
    acc(1'b0, `RSP_OFF_PTR, 8'h00);
    chk(rdata_q === ptr_exp(1'b0, 1'b0, 5'h1d));
    // Saturate with fault reset off
    for (int i = 0; i < 3; i++) begin
      seq.op(1'b1, 21'(i + 5));
      chk(lvl === 5'(30 + (i > 0)) && full === (i > 0));
    end
    chk(top === 21'h6);
    seq.op(1'b0, '0);
    chk(lvl === 5'h1e && full === 1'b1);
    fre_en <= 1'b1;
    seq.op(1'b1, 21'h100);
    chk(dreq === 1'b1 && lvl === 5'h00 && full === 1'b1);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(lvl === 5'h00 && full === 1'b1);
    // Entry thirty-one must hold the pushed value plus two; flag bits written as ones keep
    acc(1'b1, `RSP_OFF_PTR, 8'hdf);
    chk(lvl === 5'h1f && top === 21'h102 && full === 1'b1);
    acc(1'b1, `RSP_OFF_PTR, 8'hc0);
    chk(lvl === 5'h00 && full === 1'b1 && unf === 1'b0);
    // Interrupt raised, cleared, then masked
    acc(1'b1, `RSP_OFF_IRQ_MASK, 8'h03);
    chk(irq === 1'b1);
    acc(1'b1, `RSP_OFF_IRQ_STAT, 8'h02);
    chk(full === 1'b0 && irq === 1'b0);
    seq.op(1'b0, '0);
    chk(unf === 1'b1 && irq === 1'b1 && top === '0);
    acc(1'b1, `RSP_OFF_IRQ_MASK, 8'h00);
    chk(irq === 1'b0 && unf === 1'b1);
    acc(1'b0, 2'h3, 8'h00);
    summarize();
  end
endmodule // test_rsp_ctrl
`default_nettype wire
